/* File: rtl/sld_llc_dispatch.sv */
// Link control dispatcher and activation sequencer of the secure-element slave.
// What this block does
// RL1 - Windowed and activation layers always; tunnel optional.
// RL2 - Control byte selects layer, type and sub-type.
// RL3 - Sub-type zero is the slave readiness reply.
// RL4 - Sub-type two is the master activation request.
// RL5 - Unassigned activation sub-types are never sent, ignored.
// RL6 - Activation payloads are at most 29 bytes; the code acts on at most 28 after the control byte.
// RL7 - Only activation frames until initialization completes.
// RL8 - Master then opens tunnel or starts windowed link.
// RL9 - Activation frames discarded once link or tunnel up.
// RL10 - Tunnel opening keeps the windowed link context.
// RL11 - Master opens tunnel only with everything acknowledged.
// RL12 - Windowed frame closes an open tunnel session.
// RL13 - Corrupt frame uses last good frame's recovery.
// RL14 - Request holds version, capabilities, inactivity period.
// RL15 - Request bytes four onward are ignored.
// RL16 - Version byte is major one, minor zero.
// RL17 - Capability bits four and three give supply.
// RL18 - Flow control bit and reserved bits ignored.
// RL19 - Smaller of both frame sizes is used.
// RL20 - Request first, then the readiness reply.
// RL21 - Activation at 1 MHz, ready time 255 us.
// RL22 - Slave starts in low power.
// RL23 - Current capped by the master supply capability.
// RL24 - Reserved and unused frame types are discarded.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sld_map.svh"
module sld_llc_dispatch
  import sld_pkg::*;
#(
  parameter logic [11:0] READY_CYCLES = 12'(`SLD_READY_CYCLES)
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port.
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic [31:0]      regRdData,
  // Link pins.
  input  wire logic        linkClk,
  input  wire logic        linkCsN,
  input  wire logic        linkMosi,
  output logic             linkMiso,
  output logic             linkMisoOe,
  // Lower layer: frame check failed for the access in progress.
  input  wire logic        crcBad,
  // Upper layer.
  output sld_fwd_t         fwd,
  output logic             replyPending,
  output logic [1:0]       powerLimit,
  output logic [1:0]       mtuCode,
  output sld_layer_t       recoveryLayer,
  output logic             recoveryPulse
);

  sld_main_st_t q;        // Registered state.
  sld_main_st_t d;        // Next state.
  sld_link_ev_t ev;       // Events from the shifter.
  logic [7:0]   txByte;   // Byte offered to the shifter.
  sld_layer_t   rxLayer;  // Layer of the byte now arriving, if it is a control byte.
  logic         rxKeep;   // Whether a frame of that layer is accepted now.
  logic         linkOpen; // Initialization finished.
  logic         corrupt;  // Frame that ends now was corrupted.

  // Pin sampling and byte shifting.
  sld_spi_shifter u_shifter (
    .clock      (clock),
    .rst_n      (rst_n),
    .linkClk    (linkClk),
    .linkCsN    (linkCsN),
    .linkMosi   (linkMosi),
    .linkMiso   (linkMiso),
    .linkMisoOe (linkMisoOe),
    .txByte     (txByte),
    .ev         (ev)
  );

  // Classify a control byte into its layer.
  function automatic sld_layer_t classify(input logic [7:0] cb);
    sld_layer_t r;
    r = SLD_LAYER_NONE;
    if (cb[`SLD_CB_WINDOWED]) begin
      r = SLD_LAYER_WINDOWED; // RL2
    end else begin
      case (cb[`SLD_CB_TYPE_MSB:`SLD_CB_TYPE_LSB]) // RL2
        `SLD_TYPE_ACTIVATION: r = SLD_LAYER_ACTIVATION;
        `SLD_TYPE_TUNNEL:     r = SLD_LAYER_TUNNEL;
        default:              r = SLD_LAYER_NONE; // RL24
      endcase
    end
    return r;
  endfunction : classify

  // Smaller of two two-bit codes.
  function automatic logic [1:0] lesser(input logic [1:0] a, input logic [1:0] b);
    return (a < b) ? a : b;
  endfunction : lesser

  // Reply bytes: control byte, version, capabilities; filler after the end.
  always_comb begin
    txByte = `SLD_NSD_BYTE;
    if (q.phase == SLD_ST_REPLY) begin
      case (q.txIdx)
        3'h0: txByte = {3'b001, `SLD_SUB_READY}; // RL3
        3'h1: txByte = `SLD_VERSION_BYTE; // RL16
        3'h2: txByte = {4'h0, 1'b0, q.ctrl.mtu, 1'b0}; // RL18
        default: txByte = `SLD_NSD_BYTE;
      endcase
    end
  end

  // Acceptance of a new frame by layer and phase.
  always_comb begin
    linkOpen = (q.phase == SLD_ST_DONE) || (q.phase == SLD_ST_LINKED);
    rxLayer  = classify(ev.data);
    corrupt  = q.badSeen || crcBad;
    case (rxLayer)
      SLD_LAYER_ACTIVATION: rxKeep = (q.phase != SLD_ST_LINKED); // RL9
      SLD_LAYER_WINDOWED:   rxKeep = linkOpen; // RL7
      SLD_LAYER_TUNNEL:     rxKeep = linkOpen && q.ctrl.tunnelEn; // RL1
      default:              rxKeep = 1'b0; // RL24
    endcase
  end

  // Next-state logic of the whole dispatcher.
  always_comb begin
    d           = q;
    d.fwd.valid = 1'b0;
    d.fwd.first = 1'b0;
    d.fwd.last  = 1'b0;
    d.fwd.error = 1'b0;
    d.recPulse  = 1'b0;
    d.rdData    = 32'h0000_0000;
    // Software writes; only the control word is writable.
    if (regWrEn && (regAddr == `SLD_ADDR_CTRL)) begin
      d.ctrl = sld_ctrl_t'(regWrData[`SLD_CTRL_WIDTH-1:0]);
    end
    // Reads answer in the next cycle; unmapped offsets read zero.
    if (regRdEn) begin
      case (regAddr)
        `SLD_ADDR_CTRL:    d.rdData = {26'h0, q.ctrl};
        `SLD_ADDR_STATUS:  d.rdData = {21'h0, q.ctrl.windowUp, q.tunnelOpen, q.lastGood,
                                       q.power, q.mtu, q.phase};
        `SLD_ADDR_REQINFO: d.rdData = {q.reqInact, q.reqCaps, q.reqVersion}; // RL14
        default:           d.rdData = 32'h0000_0000;
      endcase
    end
    // A new access clears the per-frame state.
    if (ev.frameStart) begin
      d.rxIdx     = 8'h00;
      d.frameKeep = 1'b0;
      d.badSeen   = 1'b0;
    end
    // A corruption report sets the flag even in the clearing cycle.
    if (crcBad) begin
      d.badSeen = 1'b1; // RL13
    end
    // Received bytes.
    if (ev.byteValid) begin
      if (q.rxIdx != 8'hFF) begin
        d.rxIdx = q.rxIdx + 8'h01;
      end
      if (q.rxIdx == 8'h00) begin
        // The control byte picks the layer for the whole frame.
        d.frameLayer = rxLayer;
        d.frameKeep  = rxKeep;
        d.frameSub   = ev.data[`SLD_CB_SUB_MSB:0];
        if (rxKeep && (rxLayer != SLD_LAYER_ACTIVATION)) begin
          d.fwd.valid = 1'b1;
          d.fwd.first = 1'b1;
          d.fwd.layer = rxLayer;
          d.fwd.data  = ev.data;
        end
      end else if (q.frameKeep && (q.frameLayer != SLD_LAYER_ACTIVATION)) begin
        d.fwd.valid = 1'b1;
        d.fwd.layer = q.frameLayer;
        d.fwd.data  = ev.data;
      end
      // Request fields go to a shadow; later bytes are ignored.
      case (q.rxIdx)
        `SLD_IDX_VERSION:  d.shVersion     = ev.data; // RL14
        `SLD_IDX_CAPS:     d.shCaps        = ev.data; // RL14
        `SLD_IDX_INACT_HI: d.shInact[15:8] = ev.data; // RL14
        `SLD_IDX_INACT_LO: d.shInact[7:0]  = ev.data; // RL14
        default:           d.shCaps        = d.shCaps; // RL15
      endcase
    end
    // Reply bytes advance as the shifter takes them.
    if (ev.txTake && (q.phase == SLD_ST_REPLY) && (q.txIdx < `SLD_REPLY_LEN)) begin
      d.txIdx = q.txIdx + 3'h1;
    end
    // Ready-time wait before the reply is offered.
    if (q.phase == SLD_ST_WAIT) begin
      if (q.waitCnt >= READY_CYCLES - 12'h001) begin
        d.phase = SLD_ST_REPLY; // RL21
      end else begin
        d.waitCnt = q.waitCnt + 12'h001;
      end
    end
    // The dispatcher is linked when the windowed link or a tunnel is up.
    if ((q.phase == SLD_ST_DONE) && (q.ctrl.windowUp || q.tunnelOpen)) begin
      d.phase = SLD_ST_LINKED; // RL9
    end
    // End of an access.
    if (ev.frameEnd) begin
      if (q.phase == SLD_ST_REPLY && q.txIdx >= `SLD_REPLY_LEN) begin
        d.phase = SLD_ST_DONE; // RL20
      end
      if (corrupt && (q.rxIdx != 8'h00)) begin
        // Recovery follows the layer of the last good frame.
        d.recPulse = 1'b1; // RL13
        if (q.frameKeep && (q.frameLayer != SLD_LAYER_ACTIVATION)) begin
          d.fwd.last  = 1'b1;
          d.fwd.error = 1'b1;
        end
      end else if (q.rxIdx != 8'h00) begin
        // A refused frame is ignored, so it never steers the recovery.
        if (q.frameKeep && (q.frameLayer != SLD_LAYER_NONE)) begin
          d.lastGood = q.frameLayer; // RL13
        end
        if (q.frameKeep) begin
          case (q.frameLayer)
            SLD_LAYER_WINDOWED: begin
              d.fwd.last   = 1'b1;
              d.tunnelOpen = 1'b0; // RL12
            end
            SLD_LAYER_TUNNEL: begin
              // The windowed link bit is left alone.
              d.fwd.last   = 1'b1;
              d.tunnelOpen = 1'b1; // RL10
            end
            SLD_LAYER_ACTIVATION: begin
              // Only a complete, short request is acted on.
              if ((q.frameSub == `SLD_SUB_REQUEST) // RL5
                  && (q.rxIdx <= `SLD_ACT_MAX_LEN) // RL6
                  && (q.rxIdx >= `SLD_REQ_MIN_LEN)
                  && (q.phase != SLD_ST_LINKED)) begin // RL9
                d.reqVersion = q.shVersion;
                d.reqCaps    = q.shCaps;
                d.reqInact   = q.shInact;
                d.mtu        = lesser(q.shCaps[`SLD_CAP_MTU_MSB:`SLD_CAP_MTU_LSB],
                                      q.ctrl.mtu); // RL19
                d.power      = lesser(q.shCaps[`SLD_CAP_PWR_MSB:`SLD_CAP_PWR_LSB],
                                      q.ctrl.maxPower); // RL17 RL23
                d.phase      = SLD_ST_WAIT; // RL20
                d.waitCnt    = 12'h000;
                d.txIdx      = 3'h0;
              end
            end
            default: d.fwd.last = 1'b0;
          endcase
        end
      end
    end
  end

  // State register; power starts low, windowed link and tunnel closed.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q               <= '0;
      q.phase         <= SLD_ST_IDLE; // RL7
      q.power         <= 2'h0; // RL22
      q.lastGood      <= SLD_LAYER_ACTIVATION; // RL13
      q.frameLayer    <= SLD_LAYER_NONE;
      q.fwd.layer     <= SLD_LAYER_NONE;
      q.ctrl.mtu      <= `SLD_CTRL_MTU_RST;
      q.ctrl.tunnelEn <= `SLD_CTRL_TUN_RST;
      q.ctrl.maxPower <= `SLD_CTRL_PWR_RST;
      q.ctrl.windowUp <= `SLD_CTRL_WIN_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs.
  assign regRdData     = q.rdData;
  assign fwd           = q.fwd;
  assign replyPending  = (q.phase == SLD_ST_REPLY) && (q.txIdx < `SLD_REPLY_LEN);
  assign powerLimit    = q.power;
  assign mtuCode       = q.mtu;
  assign recoveryLayer = q.lastGood;
  assign recoveryPulse = q.recPulse;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A well-formed request ends a kept activation frame.
  sequence reqEnd_s;
    ev.frameEnd && !corrupt && q.frameKeep && (q.frameLayer == SLD_LAYER_ACTIVATION)
    && (q.frameSub == `SLD_SUB_REQUEST) && (q.rxIdx >= `SLD_REQ_MIN_LEN)
    && (q.rxIdx <= `SLD_ACT_MAX_LEN) && (q.phase != SLD_ST_LINKED);
  endsequence

  // The wait that follows it.
  sequence waitStart_s;
    (q.phase == SLD_ST_WAIT) && (q.waitCnt == 12'h000);
  endsequence

  // Request starts the ready wait next cycle.
  request_wait_a: assert property (reqEnd_s |=> waitStart_s) // RL20
    else $error("Request did not start the ready wait.");

  // Reply offered only after the full ready time.
  ready_time_a: assert property ($rose(q.phase == SLD_ST_REPLY) |->
    $past(q.waitCnt) == READY_CYCLES - 12'h001) // RL21
    else $error("Reply offered before the ready time.");

  // First reply byte is the readiness reply.
  reply_code_a: assert property ((q.phase == SLD_ST_REPLY) && (q.txIdx == 3'h0) |->
    txByte == 8'h20) // RL3
    else $error("Reply control byte wrong.");

  // Power level never exceeds the reported supply.
  power_cap_a: assert property (q.power <= q.reqCaps[4:3]) // RL23
    else $error("Power level above master supply.");

  // A new frame size never exceeds the requested or the configured size.
  mtu_min_a: assert property (q.mtu <= q.reqCaps[2:1] && q.mtu <= q.ctrl.mtu
    || !$changed(q.mtu)) // RL19
    else $error("Negotiated frame size not the smaller.");

  // Activation frames are dropped once linked.
  linked_drop_a: assert property (ev.byteValid && (q.rxIdx == 8'h00)
    && (q.phase == SLD_ST_LINKED) && (ev.data[7:5] == 3'b001) |=> !q.frameKeep) // RL9
    else $error("Activation frame kept after link up.");

  // Windowed frames are dropped before initialization ends.
  early_drop_a: assert property (ev.byteValid && (q.rxIdx == 8'h00) && ev.data[7]
    && (q.phase inside {SLD_ST_IDLE, SLD_ST_WAIT, SLD_ST_REPLY}) |=> !q.frameKeep) // RL7
    else $error("Windowed frame kept before initialization.");

  // A good windowed frame closes the tunnel.
  tunnel_close_a: assert property (ev.frameEnd && !corrupt && q.frameKeep
    && (q.frameLayer == SLD_LAYER_WINDOWED) && (q.rxIdx != 8'h00) |=> !q.tunnelOpen) // RL12
    else $error("Tunnel stayed open after windowed frame.");

  // Corrupt frame pulses recovery with the layer unchanged.
  recover_hold_a: assert property (ev.frameEnd && corrupt && (q.rxIdx != 8'h00) |=>
    recoveryPulse && $stable(recoveryLayer)) // RL13
    else $error("Corrupt frame recovery wrong.");

  // Reserved and unused types never reach the upper layer.
  no_reserved_a: assert property (fwd.valid |-> fwd.layer != SLD_LAYER_NONE) // RL24
    else $error("Reserved frame type forwarded.");

endmodule : sld_llc_dispatch
`default_nettype wire

/* File: rtl/sld_map.svh */
// Offsets, field positions, codes and timing counts of the link control dispatcher.
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// Register offsets (byte addresses, one word each).
`define SLD_ADDR_CTRL       8'h00
`define SLD_ADDR_STATUS     8'h04
`define SLD_ADDR_REQINFO    8'h08

// Control register reset values per field.
`define SLD_CTRL_MTU_RST    2'h3
`define SLD_CTRL_TUN_RST    1'h1
`define SLD_CTRL_PWR_RST    2'h1
`define SLD_CTRL_WIN_RST    1'h0
`define SLD_CTRL_WIDTH      6

// Control byte layout: bit 7 windowed, bits 6..5 type, bits 4..0 sub-type.
`define SLD_CB_WINDOWED     7
`define SLD_CB_TYPE_MSB     6
`define SLD_CB_TYPE_LSB     5
`define SLD_CB_SUB_MSB      4
`define SLD_TYPE_RESERVED   2'h0
`define SLD_TYPE_ACTIVATION 2'h1
`define SLD_TYPE_TUNNEL     2'h2
`define SLD_TYPE_UNUSED     2'h3
`define SLD_SUB_READY       5'h00
`define SLD_SUB_REQUEST     5'h02

// Activation payload limits and byte positions (index 0 is the control byte).
`define SLD_ACT_MAX_LEN     8'h1D
`define SLD_IDX_VERSION     8'h01
`define SLD_IDX_CAPS        8'h02
`define SLD_IDX_INACT_HI    8'h03
`define SLD_IDX_INACT_LO    8'h04
`define SLD_REQ_MIN_LEN     8'h05

// Capability byte fields.
`define SLD_CAP_PWR_MSB     4
`define SLD_CAP_PWR_LSB     3
`define SLD_CAP_MTU_MSB     2
`define SLD_CAP_MTU_LSB     1

// Reply contents.
`define SLD_VERSION_BYTE    8'h08
`define SLD_REPLY_LEN       3'h3
`define SLD_NSD_BYTE        8'hFF

// Timing: block clock period, ready time and the default link rate.
`define SLD_CLK_PERIOD_NS   100
`define SLD_READY_TIME_US   255
`define SLD_LINK_DEFAULT_KHZ 1000
`define SLD_READY_CYCLES \
  ((`SLD_READY_TIME_US * 1000 + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)

`endif

/* File: rtl/sld_pkg.sv */
// Types shared by the link control dispatcher and its serial shifter.
package sld_pkg;

  // Activation sequencing phases.
  typedef enum logic [2:0] {
    SLD_ST_IDLE   = 3'b000,
    SLD_ST_WAIT   = 3'b001,
    SLD_ST_REPLY  = 3'b010,
    SLD_ST_DONE   = 3'b011,
    SLD_ST_LINKED = 3'b100
  } sld_phase_t;

  // Link control layer of a payload.
  typedef enum logic [1:0] {
    SLD_LAYER_ACTIVATION = 2'b00,
    SLD_LAYER_WINDOWED   = 2'b01,
    SLD_LAYER_TUNNEL     = 2'b10,
    SLD_LAYER_NONE       = 2'b11
  } sld_layer_t;

  // Software control word.
  typedef struct packed {
    logic       windowUp;
    logic [1:0] maxPower;
    logic       tunnelEn;
    logic [1:0] mtu;
  } sld_ctrl_t;

  // Events from the serial shifter.
  typedef struct packed {
    logic       frameStart;
    logic       frameEnd;
    logic       byteValid;
    logic       txTake;
    logic [7:0] data;
  } sld_link_ev_t;

  // Forwarded payload stream.
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic       error;
    sld_layer_t layer;
    logic [7:0] data;
  } sld_fwd_t;

  // Shifter state.
  typedef struct packed {
    logic         clkMeta;
    logic         clkSync;
    logic         clkPrev;
    logic         csMeta;
    logic         csSync;
    logic         csPrev;
    logic         mosiMeta;
    logic         mosiSync;
    logic [2:0]   bitCnt;
    logic [7:0]   rxShift;
    logic [7:0]   txShift;
    sld_link_ev_t ev;
  } sld_shift_st_t;

  // Dispatcher state.
  typedef struct packed {
    sld_phase_t phase;
    sld_ctrl_t  ctrl;
    logic [7:0] rxIdx;
    sld_layer_t frameLayer;
    logic       frameKeep;
    logic [4:0] frameSub;
    logic       badSeen;
    logic [7:0] shVersion;
    logic [7:0] shCaps;
    logic [15:0] shInact;
    logic [7:0] reqVersion;
    logic [7:0] reqCaps;
    logic [15:0] reqInact;
    logic [11:0] waitCnt;
    logic [2:0] txIdx;
    logic [1:0] mtu;
    logic [1:0] power;
    sld_layer_t lastGood;
    logic       tunnelOpen;
    sld_fwd_t   fwd;
    logic       recPulse;
    logic [31:0] rdData;
  } sld_main_st_t;

endpackage : sld_pkg

/* File: rtl/sld_spi_shifter.sv */
// Serial shifter: samples the link pins on the block clock and moves bytes.
`timescale 1ns/1ps
`default_nettype none
module sld_spi_shifter
  import sld_pkg::*;
(
  // Clock and reset.
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Link pins.
  input  wire logic   linkClk,
  input  wire logic   linkCsN,
  input  wire logic   linkMosi,
  output logic        linkMiso,
  output logic        linkMisoOe,
  // Byte side.
  input  wire logic [7:0] txByte,
  output sld_link_ev_t    ev
);

  sld_shift_st_t q;     // Registered state.
  sld_shift_st_t d;     // Next state.
  logic          rise;  // Link clock rising edge inside a frame.
  logic          fall;  // Link clock falling edge inside a frame.
  logic          csFall; // Chip select asserted.
  logic          csRise; // Chip select released.

  // Edge detection reads only the second synchroniser stage and its delayed copy.
  always_comb begin
    csFall = q.csPrev && !q.csSync;
    csRise = !q.csPrev && q.csSync;
    rise   = !q.clkPrev && q.clkSync && !q.csSync;
    fall   = q.clkPrev && !q.clkSync && !q.csSync;
    d          = q;
    d.clkMeta  = linkClk;
    d.clkSync  = q.clkMeta;
    d.clkPrev  = q.clkSync;
    d.csMeta   = linkCsN;
    d.csSync   = q.csMeta;
    d.csPrev   = q.csSync;
    d.mosiMeta = linkMosi;
    d.mosiSync = q.mosiMeta;
    d.ev       = '0;
    d.ev.data  = q.ev.data;
    if (csFall) begin
      // A new access starts on a byte boundary with the first reply byte ready.
      d.bitCnt        = 3'h0;
      d.txShift       = txByte;
      d.ev.txTake     = 1'b1;
      d.ev.frameStart = 1'b1;
    end else if (csRise) begin
      // The access is over.
      d.ev.frameEnd = 1'b1;
    end else if (rise) begin
      // Sample the master data, most significant bit first.
      d.rxShift = {q.rxShift[6:0], q.mosiSync};
      d.bitCnt  = q.bitCnt + 3'h1;
      if (q.bitCnt == 3'h7) begin
        d.ev.byteValid = 1'b1;
        d.ev.data      = {q.rxShift[6:0], q.mosiSync};
      end
    end else if (fall) begin
      // Load a fresh byte at a boundary, else move to the next bit.
      if (q.bitCnt == 3'h0) begin
        d.txShift   = txByte;
        d.ev.txTake = 1'b1;
      end else begin
        d.txShift = {q.txShift[6:0], 1'b0};
      end
    end
  end

  // State register; chip select idles high.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q        <= '0;
      q.csMeta <= 1'b1;
      q.csSync <= 1'b1;
      q.csPrev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state.
  assign linkMiso   = q.txShift[7];
  assign linkMisoOe = !q.csSync;
  assign ev         = q.ev;

endmodule : sld_spi_shifter
`default_nettype wire

/* File: test/sld_llc_dispatch_tb.sv */
// Self-checking bench of the link control dispatcher.
`timescale 1ns/1ps
`default_nettype none
`include "sld_map.svh"
module sld_llc_dispatch_tb;
  import sld_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        crcBad = 1'b0;
  logic [31:0] regRdData;
  wire logic   linkClk, linkCsN, linkMosi;
  logic        linkMiso, linkMisoOe, replyPending, recoveryPulse;
  logic [1:0]  powerLimit, mtuCode, pw, mt, cPw, cMt, ePw, eMt;
  sld_layer_t  recoveryLayer;
  sld_layer_t  firstLayer = SLD_LAYER_NONE;
  sld_fwd_t    fwd;
  logic [7:0]  caps;
  logic [15:0] inact;
  logic [7:0]  cb [6] = '{8'h9C, 8'h45, 8'h05, 8'h65, 8'h22, 8'hC3};
  int          err_count = 0, checked = 0, fwdCnt = 0, recCnt = 0, cycles = 0, n0;
  int          errEnd = 0, lastCnt = 0;
  logic [7:0]  firstData = 8'h00;

  sld_llc_dispatch #(.READY_CYCLES(12'h008)) dut (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .linkClk(linkClk), .linkCsN(linkCsN), .linkMosi(linkMosi),
    .linkMiso(linkMiso), .linkMisoOe(linkMisoOe), .crcBad(crcBad), .fwd(fwd),
    .replyPending(replyPending), .powerLimit(powerLimit), .mtuCode(mtuCode),
    .recoveryLayer(recoveryLayer), .recoveryPulse(recoveryPulse));
  sld_master_model m (.linkClk(linkClk), .linkCsN(linkCsN), .linkMosi(linkMosi),
    .linkMiso(linkMiso));

  always #50 clock = ~clock;

  // Counts forwarded bytes and corrupt-frame pulses, and cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (fwd.valid) fwdCnt <= fwdCnt + 1;
    if (fwd.valid && fwd.first) firstLayer <= fwd.layer;
    if (fwd.valid && fwd.first) firstData <= fwd.data;
    if (fwd.last) lastCnt <= lastCnt + 1;
    if (fwd.last && fwd.error) errEnd <= errEnd + 1;
    if (recoveryPulse) recCnt <= recCnt + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // Smaller of two codes.
  function automatic logic [1:0] min2(input logic [1:0] a, input logic [1:0] b);
    return (a < b) ? a : b;
  endfunction : min2

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask : wr

  // Read; the data stand in the cycle after the strobe.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 chk(what, exp, regRdData);
  endtask : rdchk

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    void'($urandom(32'ha0fd));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdchk("ctrl", `SLD_ADDR_CTRL, 32'h0000000F);
    wr(`SLD_ADDR_STATUS, 32'hFFFFFFFF);
    rdchk("status", `SLD_ADDR_STATUS, 32'h0);
    rdchk("unmapped", 8'h0C, 32'h0);
    chk("power", 32'h0, {30'h0, powerLimit});
    chk("oe idle", 32'h0, {31'h0, linkMisoOe});
    m.xfer({8'hA5, 8'h11, 48'h0}, 2);
    m.xfer({8'h23, 8'h08, 8'h0E, 40'h0}, 5);
    chk("early fwd", 32'h0, fwdCnt);
    rdchk("bad sub", `SLD_ADDR_STATUS, 32'h0);
    {pw, mt, cPw, cMt} = 8'($urandom);
    caps = {3'b000, pw, mt, 1'b0};
    inact = 16'($urandom);
    ePw = min2(pw, cPw);
    eMt = min2(mt, cMt);
    wr(`SLD_ADDR_CTRL, {26'h0, 1'b0, cPw, 1'b1, cMt});
    m.request(caps, inact);
    chk("pending", 32'h1, {31'h0, replyPending});
    rdchk("reqinfo", `SLD_ADDR_REQINFO, {inact, caps, 8'h08});
    m.xfer(64'hFFFFFFFF_FFFFFFFF, 4);
    chk("reply ctrl", 32'h20, m.rxBuf[0]);
    chk("reply ver", 32'h08, m.rxBuf[1]);
    chk("reply caps", {29'h0, cMt, 1'b0}, m.rxBuf[2]);
    chk("pending", 32'h0, {31'h0, replyPending});
    chk("mtu", eMt, mtuCode);
    chk("power", ePw, powerLimit);
    rdchk("done", `SLD_ADDR_STATUS, {21'h0, 4'h0, ePw, eMt, 3'h3});
    for (int i = 0; i < 6; i++) begin
      n0 = fwdCnt;
      m.xfer({cb[i], 8'h5A, 8'hA5, 8'h3C, 8'hC3, 24'h0}, 5);
      chk("fwd count", (i < 2 || i == 5) ? 5 : 0, fwdCnt - n0);
      if (i == 1) chk("layer", SLD_LAYER_TUNNEL, firstLayer);
      if (i == 5) chk("layer", SLD_LAYER_WINDOWED, firstLayer);
      if (i == 5) chk("first data", 32'hC3, firstData);
    end
    chk("frame ends", 32'h3, lastCnt);
    rdchk("linked", `SLD_ADDR_STATUS, {21'h0, 4'h1, ePw, eMt, 3'h4});
    fork
      m.xfer({8'h81, 56'h0}, 3);
      begin
        #3000;
        chk("oe busy", 32'h1, {31'h0, linkMisoOe});
        @(posedge clock);
        crcBad <= 1'b1;
        @(posedge clock);
        crcBad <= 1'b0;
      end
    join
    chk("recovery", 32'h1, recCnt);
    chk("error end", 32'h1, errEnd);
    chk("rec layer", SLD_LAYER_WINDOWED, recoveryLayer);
    complete_run();
  end
endmodule : sld_llc_dispatch_tb
`default_nettype wire

/* File: test/sld_master_model.sv */
// Link master model that drives the serial pins of the dispatcher.
`timescale 1ns/1ps
`default_nettype none
module sld_master_model (
  // Link pins.
  output logic      linkClk,
  output logic      linkCsN,
  output logic      linkMosi,
  input  wire logic linkMiso
);
  logic [7:0] rxBuf [8]; // Bytes seen on the slave data line.

  // Clock stands low and select high outside frames.
  initial begin
    linkClk = 1'b0;
    linkCsN = 1'b1;
    linkMosi = 1'b1;
  end

  // Sends n bytes of tx, first byte in the top bits, MSB first in mode 0.
  task automatic xfer(input logic [63:0] tx, input int n);
    // Step off the block clock edge so no pin moves while it samples.
    #1;
    linkCsN = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        linkMosi = tx[63 - 8 * i - (7 - b)];
        #400 linkClk = 1'b1;
        rxBuf[i][b] = linkMiso;
        #400 linkClk = 1'b0;
      end
    end
    #400 linkCsN = 1'b1;
    // A released data line must not keep showing its last bit.
    linkMosi = ~linkMosi;
    #1300;
  endtask : xfer

  // Activation request: version, capabilities, inactivity period.
  task automatic request(input logic [7:0] caps, input logic [15:0] inact);
    xfer({8'h22, 8'h08, caps, inact, 24'hFFFFFF}, 5);
  endtask : request
endmodule : sld_master_model
`default_nettype wire
